// ==== design/wwd_pkg.sv ====
// Package for the windowed watchdog timer: register map, fields, codes, timing.
// Assumes a 32-bit APB slave port and a 1 kHz counter clock.
package wwd_pkg;
   // Register indices as printed; byte address is four times the index.
   localparam logic [7:0] CTRL_INDEX   = 8'h00;
   localparam logic [7:0] STATUS_INDEX = 8'h01;
   localparam int         APB_AW       = 8;
   localparam logic [7:0] CTRL_ADDR    = 8'(CTRL_INDEX * 4);
   localparam logic [7:0] STATUS_ADDR  = 8'(STATUS_INDEX * 4);

   // Control register fields.
   localparam int PERIOD_LSB = 0;
   localparam int WINDOW_LSB = 4;
   localparam int FIELD_W    = 4;
   localparam int CTRL_W     = 8;

   // Status register bits.
   localparam int STATUS_BUSY_BIT = 0;
   localparam int STATUS_LOCK_BIT = 7;
   localparam logic [7:0] STATUS_RESET = 8'h00;

   // Time-out codes: 0 is off, 1 to 11 select 8 to 8192 counter cycles.
   localparam logic [3:0] CODE_OFF = 4'h0;
   localparam logic [3:0] CODE_MIN = 4'h1;
   localparam logic [3:0] CODE_MAX = 4'hb;

   // Timing in the counter-clock domain.
   localparam int WDC_FREQ_HZ    = 1000;
   localparam int MIN_TIMEOUT_MS = 8;
   localparam int MIN_CYCLES     = (MIN_TIMEOUT_MS * WDC_FREQ_HZ) / 1000;
   localparam int CNT_W_MIN      = 14;

   // Boot sequence: fuse is loaded once its synchroniser has settled.
   localparam logic [1:0] BOOT_LOAD = 2'h2;
   localparam logic [1:0] BOOT_DONE = 2'h3;

   typedef enum logic [1:0] {
      ST_OFF    = 2'b00,
      ST_NORMAL = 2'b01,
      ST_CLOSED = 2'b10,
      ST_OPEN   = 2'b11
   } wwd_state_type;
endpackage

// ==== design/wwd_sync.sv ====
// Two-flop level synchroniser, one bit lane per width bit.
// Assumes each lane is a level or a toggle that holds for several target cycles.
`timescale 1ns/1ps
`default_nettype none
module wwd_sync #(
   parameter int WIDTH = 1
) (
   // Destination clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // Data
   input  wire logic [WIDTH-1:0] d,
   output var  logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= '0;
         q    <= '0;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule
`default_nettype wire

// ==== design/wwd_timer.sv ====
// Windowed watchdog timer: APB registers on sys_clk, counter on the 1 kHz clock.
// Assumes restartReq, guardOpen, dbgMode and dbgHalt come from core logic on sys_clk,
// bootFuse is a static fuse level and wdcClk runs from its own oscillator.
`timescale 1ns/1ps
`default_nettype none
module wwd_timer
   import wwd_pkg::*;
#(
   parameter int CNT_W = wwd_pkg::CNT_W_MIN
) (
   // System clock and reset
   input  wire logic                       sys_clk,
   input  wire logic                       rst_n,
   // Watchdog counter clock
   input  wire logic                       wdcClk,
   // APB slave
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [wwd_pkg::APB_AW-1:0] paddr,
   input  wire logic [31:0]                pwdata,
   output var  logic [31:0]                prdata,
   output var  logic                       pready,
   output var  logic                       pslverr,
   // Core side
   input  wire logic                       restartReq,
   input  wire logic                       guardOpen,
   input  wire logic                       dbgMode,
   input  wire logic                       dbgHalt,
   // Boot fuse
   input  wire logic [wwd_pkg::CTRL_W-1:0] bootFuse,
   // System reset request
   output var  logic                       sysResetReq
);
   import wwd_pkg::*;

   if (CNT_W < CNT_W_MIN) begin : g_check
      $error("CNT_W too small for the longest time-out");
   end

   function automatic logic codeValid(input logic [FIELD_W-1:0] code);
      return (code >= CODE_MIN) && (code <= CODE_MAX);
   endfunction

   function automatic logic [CNT_W-1:0] codeCycles(input logic [FIELD_W-1:0] code);
      logic [CNT_W-1:0] base;
      base = CNT_W'(MIN_CYCLES);
      return base << (code - CODE_MIN);
   endfunction

   // System clock domain: control shadow, lock, restart toggle and the APB slave.
   logic [CTRL_W-1:0] ctrl;
   logic              lock;
   logic [1:0]        bootStage;
   logic [CTRL_W-1:0] fuseSync;
   logic              ctrlTog;
   logic              rstTog;
   logic [1:0]        ackSync;
   logic              ctrlBusy;
   logic              restartBusy;
   logic              setupPhase;
   logic              wrEn;
   logic              ctrlWrOk;
   logic              lockWr;

   assign ctrlBusy    = ctrlTog ^ ackSync[0];
   assign restartBusy = rstTog ^ ackSync[1];
   assign setupPhase  = psel && !penable;
   assign wrEn        = psel && penable && pready && pwrite;
   assign ctrlWrOk    = wrEn && (paddr == CTRL_ADDR) && guardOpen && !lock
                        && !ctrlBusy && (bootStage == BOOT_DONE);
   assign lockWr      = wrEn && (paddr == STATUS_ADDR) && guardOpen;

   // The fuse is a pin level, so it is synchronised before the boot load reads it.
   wwd_sync #(
      .WIDTH (CTRL_W)
   ) u_fuseSync (
      .clk   (sys_clk),
      .rst_n (rst_n),
      .d     (bootFuse),
      .q     (fuseSync)
   );

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         bootStage <= 2'h0;
      end else if (bootStage != BOOT_DONE) begin
         bootStage <= bootStage + 2'h1;
      end
   end

   // Control shadow; held steady while a transfer to the counter domain is open.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl    <= '0;
         ctrlTog <= 1'b0;
      end else if (bootStage == BOOT_LOAD) begin
         ctrl    <= fuseSync;
         ctrlTog <= !ctrlTog;
      end else if (ctrlWrOk) begin
         ctrl    <= pwdata[CTRL_W-1:0];
         ctrlTog <= !ctrlTog;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         lock <= 1'b0;
      end else if (bootStage == BOOT_LOAD) begin
         lock <= codeValid(fuseSync[PERIOD_LSB +: FIELD_W]);
      end else if (lockWr && pwdata[STATUS_LOCK_BIT]) begin
         lock <= 1'b1;
      end else if (lockWr && dbgMode) begin
         lock <= 1'b0;
      end
   end

   // A restart issued while the previous one is still crossing is dropped.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rstTog <= 1'b0;
      end else if (restartReq && !restartBusy) begin
         rstTog <= !rstTog;
      end
   end

   // APB answers one cycle after setup; unmapped addresses report an error.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end else begin
         pready  <= setupPhase;
         pslverr <= setupPhase && (paddr != CTRL_ADDR) && (paddr != STATUS_ADDR);
         prdata  <= '0;
         if (setupPhase && !pwrite && paddr == CTRL_ADDR) begin
            prdata[CTRL_W-1:0] <= ctrl;
         end else if (setupPhase && !pwrite && paddr == STATUS_ADDR) begin
            prdata[STATUS_LOCK_BIT] <= lock;
            prdata[STATUS_BUSY_BIT] <= ctrlBusy;
         end
      end
   end

   // Counter clock domain: handshake ends, state machine and counter.
   logic              wdcRstMeta;
   logic              wdcRst_n;
   logic [2:0]        fwdSync;
   logic              ctrlSeen;
   logic              rstSeen;
   logic [CTRL_W-1:0] wdcCtrl;
   wwd_state_type     state;
   wwd_state_type     next_state;
   logic [CNT_W-1:0]  cnt;
   logic [CNT_W-1:0]  next_cnt;
   logic              next_fire;
   logic              ctrlNew;
   logic              restartNew;
   logic              halted;
   logic [CNT_W-1:0]  periodCycles;
   logic [CNT_W-1:0]  windowCycles;
   logic              periodOn;
   logic              windowOn;

   // Reset release is retimed to wdcClk, so no counter flop leaves reset close to its edge.
   always_ff @(posedge wdcClk or negedge rst_n) begin
      if (!rst_n) begin
         wdcRstMeta <= 1'b0;
         wdcRst_n   <= 1'b0;
      end else begin
         wdcRstMeta <= 1'b1;
         wdcRst_n   <= wdcRstMeta;
      end
   end

   // Toggles and the halt level cross over; the seen toggles return as acknowledges.
   wwd_sync #(
      .WIDTH (3)
   ) u_fwdSync (
      .clk   (wdcClk),
      .rst_n (wdcRst_n),
      .d     ({dbgHalt, rstTog, ctrlTog}),
      .q     (fwdSync)
   );

   wwd_sync #(
      .WIDTH (2)
   ) u_ackSync (
      .clk   (sys_clk),
      .rst_n (rst_n),
      .d     ({rstSeen, ctrlSeen}),
      .q     (ackSync)
   );

   assign ctrlNew      = fwdSync[0] ^ ctrlSeen;
   assign restartNew   = fwdSync[1] ^ rstSeen;
   assign halted       = fwdSync[2];
   assign periodOn     = codeValid(wdcCtrl[PERIOD_LSB +: FIELD_W]);
   assign windowOn     = codeValid(wdcCtrl[WINDOW_LSB +: FIELD_W]);
   assign periodCycles = codeCycles(wdcCtrl[PERIOD_LSB +: FIELD_W]);
   assign windowCycles = codeCycles(wdcCtrl[WINDOW_LSB +: FIELD_W]);

   always_ff @(posedge wdcClk or negedge wdcRst_n) begin
      if (!wdcRst_n) begin
         ctrlSeen <= 1'b0;
         rstSeen  <= 1'b0;
         wdcCtrl  <= '0;
      end else begin
         rstSeen <= fwdSync[1];
         if (ctrlNew) begin
            ctrlSeen <= fwdSync[0];
            wdcCtrl  <= ctrl;
         end
      end
   end

   // Sleep modes do not gate wdcClk, and no sys_clk edge is needed to fire.
   always_comb begin
      next_state = state;
      next_cnt   = cnt + CNT_W'(1);
      next_fire  = 1'b0;
      if (halted) begin
         next_cnt   = '0;
         next_state = periodOn ? ST_NORMAL : ST_OFF;
      end else if (ctrlNew) begin
         next_cnt   = '0;
         next_state = ST_NORMAL;
      end else begin
         unique case (state)
            ST_OFF: begin
               next_cnt   = '0;
               next_state = periodOn ? ST_NORMAL : ST_OFF;
            end
            ST_NORMAL: begin
               if (!periodOn) begin
                  next_cnt   = '0;
                  next_state = ST_OFF;
               end else if (restartNew) begin
                  next_cnt   = '0;
                  next_state = windowOn ? ST_CLOSED : ST_NORMAL;
               end else if (next_cnt == periodCycles) begin
                  next_fire = 1'b1;
               end
            end
            ST_CLOSED: begin
               if (restartNew) begin
                  next_fire = 1'b1;
               end else if (next_cnt == windowCycles) begin
                  next_cnt   = '0;
                  next_state = ST_OPEN;
               end
            end
            ST_OPEN: begin
               if (restartNew) begin
                  next_cnt   = '0;
                  next_state = ST_CLOSED;
               end else if (next_cnt == periodCycles) begin
                  next_fire = 1'b1;
               end
            end
         endcase
      end
   end

   // The request holds until the system reset that it causes clears the block.
   always_ff @(posedge wdcClk or negedge wdcRst_n) begin
      if (!wdcRst_n) begin
         state       <= ST_OFF;
         cnt         <= '0;
         sysResetReq <= 1'b0;
      end else if (!sysResetReq) begin
         state       <= next_state;
         cnt         <= next_cnt;
         sysResetReq <= next_fire;
      end
   end
endmodule
`default_nettype wire

// ==== dv/wwd_core_model.sv ====
// Core-side model: restart strobes and the unlock guard level.
// Assumes its tasks are called just after a rising sys_clk edge.
`timescale 1ns/1ps
`default_nettype none
module wwd_core_model (
   // Clock
   input  wire logic sys_clk,
   // Core restart strobe and guard level
   output var  logic restartReq,
   output var  logic guardOpen
);
   initial begin
      restartReq = 1'b0;
      guardOpen  = 1'b0;
   end
   // Callers space restarts beyond the crossing time, else they are dropped.
   task automatic restart();
      restartReq <= 1'b1;
      @(posedge sys_clk);
      restartReq <= 1'b0;
   endtask
   task automatic guard(input logic g);
      guardOpen <= g;
   endtask
endmodule
`default_nettype wire

// ==== dv/wwd_timer_properties.sv ====
// Checker for the watchdog block: APB answers and the reset request.
// Assumes it is bound to wwd_timer and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module wwd_timer_properties
   import wwd_pkg::*;
(
   input wire logic                       sys_clk,
   input wire logic                       rst_n,
   input wire logic                       psel,
   input wire logic                       penable,
   input wire logic [wwd_pkg::APB_AW-1:0] paddr,
   input wire logic [31:0]                prdata,
   input wire logic                       pready,
   input wire logic                       pslverr,
   input wire logic                       dbgHalt,
   input wire logic                       restartReq,
   input wire logic                       sysResetReq
);
   logic [7:0] haltCnt;
   // Saturates, so a long halt never wraps back out of the quiet-check window.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) haltCnt <= 8'h00;
      else if (!dbgHalt) haltCnt <= 8'h00;
      else if (haltCnt != 8'hff) haltCnt <= haltCnt + 8'h01;
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   chk_setup_ready: assert property (psel && !penable |=> pready)
      else $error("pready missing after setup");
   chk_ready_single: assert property (pready |=> !pready)
      else $error("pready held too long");
   chk_ready_cause: assert property (pready |-> $past(psel) && !$past(penable))
      else $error("pready without setup");
   chk_unmapped_err: assert property (
      pready && paddr != CTRL_ADDR && paddr != STATUS_ADDR |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   chk_mapped_ok: assert property (
      pready && (paddr == CTRL_ADDR || paddr == STATUS_ADDR) |-> !pslverr && prdata[31:8] == 24'h0)
      else $error("mapped access answered wrongly");
   chk_status_gap: assert property (pready && paddr == STATUS_ADDR |-> prdata[6:1] == 6'h00)
      else $error("status reserved bits set");
   chk_reset_sticky: assert property (sysResetReq |=> sysResetReq)
      else $error("reset request dropped");
   chk_halt_quiet: assert property (haltCnt > 8'h3c |-> !$rose(sysResetReq))
      else $error("reset request during halt");
   cover property ($rose(sysResetReq));
   cover property (pready && pslverr);
   cover property (restartReq);
endmodule
bind wwd_timer wwd_timer_properties u_props (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
   .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .dbgHalt(dbgHalt), .restartReq(restartReq), .sysResetReq(sysResetReq));
`default_nettype wire

// ==== dv/wwd_timer_tb.sv ====
// Self-checking bench for the windowed watchdog timer.
// Assumes a 100 MHz sys_clk and a fast stand-in counter clock.
`timescale 1ns/1ps
`default_nettype none
module wwd_timer_tb;
   import wwd_pkg::*;
   logic        sys_clk = 1'b0;
   logic        wdcClk = 1'b0;
   logic        rst_n, psel, penable, pwrite, pready, pslverr, rerr;
   logic        restartReq, guardOpen, dbgMode, dbgHalt, sysResetReq;
   logic [7:0]  paddr, bootFuse;
   logic [31:0] pwdata, prdata, rdata;
   int          err_count = 0;
   int          n_compared = 0;
   always #5 sys_clk = ~sys_clk;
   // Counter clock about ten times slower than sys_clk keeps runs short.
   always #53 wdcClk = ~wdcClk;
   wwd_timer u_wwd_timer (.sys_clk(sys_clk), .rst_n(rst_n), .wdcClk(wdcClk), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .restartReq(restartReq), .guardOpen(guardOpen),
      .dbgMode(dbgMode), .dbgHalt(dbgHalt), .bootFuse(bootFuse), .sysResetReq(sysResetReq));
   wwd_core_model u_wwd_core_model (.sys_clk(sys_clk), .restartReq(restartReq),
      .guardOpen(guardOpen));
   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic tmo(input string s);
      err_count++;
      $display("Error %s expected done seen stuck", s);
      wrap_up();
   endtask
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         err_count++;
         $display("Error %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int i;
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge sys_clk);
         i++;
      end while (pready !== 1'b1 && i < 20);
      if (pready !== 1'b1) tmo("pready");
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(a, 1'b0, 32'h0);
      chk("prdata", e, rdata);
   endtask
   task automatic gw(input logic [7:0] a, input logic [31:0] d);
      u_wwd_core_model.guard(1'b1);
      apb(a, 1'b1, d);
      u_wwd_core_model.guard(1'b0);
   endtask
   task automatic waitIdle();
      int i;
      rdata = 32'h1;
      for (i = 0; i < 60 && rdata[0] !== 1'b0; i++) apb(STATUS_ADDR, 1'b0, 32'h0);
      if (rdata[0] !== 1'b0) tmo("busy");
   endtask
   task automatic waitFire(input int n, input logic e);
      int i;
      for (i = 0; i < n && sysResetReq !== 1'b1; i++) @(posedge sys_clk);
      chk("sysResetReq", {31'h0, e}, {31'h0, sysResetReq});
   endtask
   task automatic rst(input logic [7:0] f);
      rst_n <= 1'b0;
      bootFuse <= f;
      dbgHalt <= 1'b0;
      dbgMode <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (5) @(posedge sys_clk);
      waitIdle();
   endtask
   task automatic t_boot_off();
      rst(8'h00);
      rd(CTRL_ADDR, 32'h0);
      rd(STATUS_ADDR, 32'h0);
      apb(8'h08, 1'b0, 32'h0);
      chk("pslverr", 32'h1, {31'h0, rerr});
      waitFire(100, 1'b0);
   endtask
   task automatic t_timeout();
      rst(8'h00);
      apb(CTRL_ADDR, 1'b1, 32'h1);
      rd(CTRL_ADDR, 32'h0);
      gw(CTRL_ADDR, 32'h1);
      rd(STATUS_ADDR, 32'h1);
      waitFire(75, 1'b0);
      waitFire(60, 1'b1);
   endtask
   task automatic t_restart();
      rst(8'h00);
      gw(CTRL_ADDR, 32'h2);
      waitIdle();
      repeat (5) begin
         repeat (60) @(posedge sys_clk);
         u_wwd_core_model.restart();
      end
      waitFire(30, 1'b0);
   endtask
   task automatic t_window();
      rst(8'h00);
      gw(CTRL_ADDR, 32'h12);
      waitIdle();
      repeat (20) @(posedge sys_clk);
      u_wwd_core_model.restart();
      waitFire(120, 1'b0);
      u_wwd_core_model.restart();
      waitFire(40, 1'b0);
      u_wwd_core_model.restart();
      waitFire(80, 1'b1);
   endtask
   task automatic t_halt();
      rst(8'h00);
      gw(CTRL_ADDR, 32'h11);
      waitIdle();
      // The halt lands mid-period, so a counter that kept running or kept its count shows.
      repeat (30) @(posedge sys_clk);
      dbgHalt <= 1'b1;
      waitFire(200, 1'b0);
      dbgHalt <= 1'b0;
      waitFire(90, 1'b0);
      waitFire(60, 1'b1);
   endtask
   task automatic t_fuse();
      rst(8'h02);
      rd(STATUS_ADDR, 32'h80);
      rd(CTRL_ADDR, 32'h2);
      gw(CTRL_ADDR, 32'h0);
      rd(CTRL_ADDR, 32'h2);
      gw(STATUS_ADDR, 32'h0);
      rd(STATUS_ADDR, 32'h80);
      dbgMode <= 1'b1;
      gw(STATUS_ADDR, 32'h0);
      rd(STATUS_ADDR, 32'h0);
      waitFire(200, 1'b1);
   endtask
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      t_boot_off();
      t_timeout();
      t_restart();
      t_window();
      t_halt();
      t_fuse();
      wrap_up();
   end
   initial begin
      #900000;
      tmo("run");
   end
endmodule
`default_nettype wire
